// ### rtl/adtp_cfg.svh
`ifndef ADTP_CFG_SVH
`define ADTP_CFG_SVH
// Register offsets of the pattern block.
`define ADTP_OFF_TEST_SEL 8'h0d
`define ADTP_OFF_USER1_A  8'h19
`define ADTP_OFF_USER1_B  8'h1a
`define ADTP_OFF_USER2_A  8'h1b
`define ADTP_OFF_USER2_B  8'h1c
// Reset value of every pattern register; a zero mode code means normal data.
`define ADTP_REG_RST      8'h00
// Field positions inside the test mode register.
`define ADTP_MODE_MSB     3
`define ADTP_PN_RST_LO    4
`define ADTP_PN_RST_HI    5
// Fixed words, 14 bits, a 12-bit word sits in bits 13 to 2.
`define ADTP_PAT_MID      14'h2000
`define ADTP_PAT_ONES     14'h3fff
`define ADTP_PAT_ZEROS    14'h0000
`define ADTP_PAT_CHK_A    14'h2aaa
`define ADTP_PAT_CHK_B    14'h1555
`define ADTP_PAT_SYNC14   14'h007f
`define ADTP_PAT_SYNC12   14'h00fc
`define ADTP_PAT_MIX14    14'h2867
`define ADTP_PAT_MIX12    14'h28cc
`define ADTP_PAT_ONEBIT   14'h2000
`define ADTP_PAT_STRAP    14'h2000
// Generator lengths, taps and seed.
`define ADTP_PN9_LEN      9
`define ADTP_PN9_TAP      5
`define ADTP_LONG_PRBS_LEN     23
`define ADTP_LONG_PRBS_TAP     18
`define ADTP_PN_SEED      23'h7fffff
// Frame bit counts, last bit index and half point.
`define ADTP_LAST14       4'hd
`define ADTP_LAST12       4'hb
`define ADTP_HALF14       4'h7
`define ADTP_HALF12       4'h6
`endif

// ### rtl/adtp_pkg.sv
package adtp_pkg;
   // Test mode codes held in the low nibble of the test mode register.
   typedef enum logic [3:0] {
      ADTP_M_OFF      = 4'b0000,
      ADTP_M_MID      = 4'b0001,
      ADTP_M_PFS      = 4'b0010,
      ADTP_M_NFS      = 4'b0011,
      ADTP_M_CHECKER  = 4'b0100,
      ADTP_M_PN_LONG  = 4'b0101,
      ADTP_M_PN_SHORT = 4'b0110,
      ADTP_M_WORD_TGL = 4'b0111,
      ADTP_M_USER     = 4'b1000,
      ADTP_M_BIT_TGL  = 4'b1001,
      ADTP_M_SYNC     = 4'b1010,
      ADTP_M_ONE_BIT  = 4'b1011,
      ADTP_M_MIXED    = 4'b1100
   } adtp_mode_t;
   // One bank's copy of the pattern registers.
   typedef struct packed {
      logic [7:0] test_pattern_select;
      logic [7:0] user_word1_part_a;
      logic [7:0] user_word1_part_b;
      logic [7:0] user_word2_part_a;
      logic [7:0] user_word2_part_b;
   } adtp_bank_regs_t;
   // A decoded configuration write from the serial port front end.
   typedef struct packed {
      logic       wr_en;
      logic [7:0] addr;
      logic [7:0] wdata;
   } adtp_cfg_wr_t;
   // Conversion results of all sixteen channels, offset binary.
   typedef logic [15:0][13:0] adtp_samples_t;
   // Words for one bank's eight lanes plus the frame length flag.
   typedef struct packed {
      logic [7:0][13:0] word;
      logic             short_frame;
   } adtp_bank_load_t;
endpackage

// ### rtl/adtp_pattern_gen.sv
`timescale 1ns/1ps
`include "adtp_cfg.svh"
module adtp_pattern_gen
   import adtp_pkg::*;
(
   input  wire logic                    sys_clk,
   input  wire logic                    rst,
   input  wire logic                    link_clk,
   input  wire logic                    serial_clock_pattern_strap_pin,
   input  wire logic                    serial_io_format_strap_pin,
   input  wire logic                    bank1_chip_select_n,
   input  wire logic                    bank2_chip_select_n,
   input  wire adtp_pkg::adtp_cfg_wr_t  cfg_wr,
   input  wire logic [7:0]              cfg_rd_addr,
   output logic [7:0]                   cfg_rdata,
   input  wire logic                    res_12bit_sel,
   input  wire logic                    twos_comp_sel,
   input  wire adtp_pkg::adtp_samples_t conv_data,
   output logic [15:0]                  serial_data_lanes,
   output logic                         bank1_frame_clock,
   output logic                         bank2_frame_clock,
   output logic                         bank1_data_clock,
   output logic                         bank2_data_clock
);
   import adtp_pkg::*;

   // Converts an offset binary word to the selected coding.
   function automatic logic [13:0] adtp_fmt(input logic [13:0] w, input logic twos);
      return twos ? {~w[13], w[12:0]} : w;
   endfunction

   // Runs fourteen serial steps of a Fibonacci generator, oldest bit first.
   function automatic logic [36:0] adtp_prbs_step(input logic [22:0] s,
                                                 input int unsigned len,
                                                 input int unsigned tap);
      logic [22:0] st;
      logic [13:0] w;
      logic        fb;
      st = s;
      w  = 14'h0000;
      fb = 1'b0;
      for (int i = 0; i < 14; i++) begin
         fb = st[len-1] ^ st[tap-1];
         w  = {w[12:0], st[len-1]};
         st = {st[21:0], fb};
      end
      return {w, st};
   endfunction

   // Pin synchronisers, order {cs2, cs1, format strap, pattern strap}.
   logic [3:0]            pin_meta;     // First stage, read only by pin_sync.
   logic [3:0]            pin_sync;     // Second stage, safe to use.
   logic                  strap_done;   // Power-up strap has been sampled.
   logic                  strap_pat;    // Pattern strap was active at power-up.
   logic [1:0]            strap_wait;   // Edges since release, filled from the bottom.
   adtp_bank_regs_t       regs [2];     // Register copy per bank.
   logic [1:0]            bank_sel;     // Bank chip select is low.
   logic                  both_off;     // Both chip selects high.
   logic                  twos;         // Effective output coding.
   logic [22:0]           pn9 [2];      // Short generator state per bank.
   logic [22:0]           long_prbs [2];     // Long generator state per bank.
   logic [1:0]            alt;          // Word one or two of a pair.
   logic [1:0]            req;          // Request toggles, sys domain.
   logic [1:0]            ack_meta;     // Acknowledge sync, first stage.
   logic [1:0]            ack_sync;     // Acknowledge sync, second stage.
   logic [1:0]            ack_out;      // Acknowledge toggles, made on the link side.
   adtp_bank_load_t       hold [2];     // Word set offered to the link side.

   assign bank_sel = ~pin_sync[3:2];
   assign both_off = pin_sync[3] & pin_sync[2];
   // coding comes from the strap while the port is off.
   assign twos     = both_off ? pin_sync[1] : twos_comp_sel;

   // Two flip-flops on every pin, the chip selects reset to deselected.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         pin_meta <= 4'hc;
         pin_sync <= 4'hc;
      end else begin
         pin_meta <= {bank2_chip_select_n, bank1_chip_select_n,
                      serial_io_format_strap_pin, serial_clock_pattern_strap_pin};
         pin_sync <= pin_meta;
      end
   end

   // The strap is taken once, on the third edge after release.
   // Any earlier edge would read the synchroniser's reset value, not the pin.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         strap_wait <= 2'b00;
         strap_done <= 1'b0;
         strap_pat  <= 1'b0;
      end else begin
         strap_wait <= {strap_wait[0], 1'b1};
         if (strap_wait[1] && !strap_done) begin
            strap_done <= 1'b1;
            strap_pat  <= pin_sync[0] & both_off;
         end
      end
   end

   // Register writes land only in banks whose select is low.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         for (int b = 0; b < 2; b++) begin
            regs[b] <= {5{`ADTP_REG_RST}};
         end
      end else begin
         for (int b = 0; b < 2; b++) begin
            if (cfg_wr.wr_en && bank_sel[b]) begin
               case (cfg_wr.addr)
                  `ADTP_OFF_TEST_SEL: regs[b].test_pattern_select <= cfg_wr.wdata;
                  `ADTP_OFF_USER1_A:  regs[b].user_word1_part_a   <= cfg_wr.wdata;
                  `ADTP_OFF_USER1_B:  regs[b].user_word1_part_b   <= cfg_wr.wdata;
                  `ADTP_OFF_USER2_A:  regs[b].user_word2_part_a   <= cfg_wr.wdata;
                  `ADTP_OFF_USER2_B:  regs[b].user_word2_part_b   <= cfg_wr.wdata;
                  default: ;
               endcase
            end
         end
      end
   end

   // Read back from bank 1 when it is selected, else bank 2; other addresses give zero.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cfg_rdata <= `ADTP_REG_RST;
      end else begin
         case (cfg_rd_addr)
            `ADTP_OFF_TEST_SEL: cfg_rdata <= regs[bank_sel[0] ? 0 : 1].test_pattern_select;
            `ADTP_OFF_USER1_A:  cfg_rdata <= regs[bank_sel[0] ? 0 : 1].user_word1_part_a;
            `ADTP_OFF_USER1_B:  cfg_rdata <= regs[bank_sel[0] ? 0 : 1].user_word1_part_b;
            `ADTP_OFF_USER2_A:  cfg_rdata <= regs[bank_sel[0] ? 0 : 1].user_word2_part_a;
            `ADTP_OFF_USER2_B:  cfg_rdata <= regs[bank_sel[0] ? 0 : 1].user_word2_part_b;
            default:            cfg_rdata <= 8'h00;
         endcase
      end
   end

   // Chooses one lane's word for a bank; data comes in offset binary.
   function automatic logic [13:0] adtp_pick(input adtp_bank_regs_t r, input logic a,
                                             input logic sh, input logic [13:0] p9,
                                             input logic [13:0] p23,
                                             input logic [13:0] conv, input logic tw);
      logic [13:0] w;
      logic        f;
      w = conv;
      f = 1'b1;
      case (adtp_mode_t'(r.test_pattern_select[`ADTP_MODE_MSB:0]))
         ADTP_M_MID:      w = `ADTP_PAT_MID;
         ADTP_M_PFS:      w = `ADTP_PAT_ONES;
         ADTP_M_NFS:      w = `ADTP_PAT_ZEROS;
         ADTP_M_PN_LONG:  w = p23;
         ADTP_M_PN_SHORT: w = p9;
         ADTP_M_CHECKER: begin
            w = a ? `ADTP_PAT_CHK_B : `ADTP_PAT_CHK_A;
            f = 1'b0;
         end
         ADTP_M_WORD_TGL: begin
            w = a ? `ADTP_PAT_ZEROS : `ADTP_PAT_ONES;
            f = 1'b0;
         end
         ADTP_M_USER: begin
            // The pair forms a 16-bit word whose top fourteen bits are sent.
            w = a ? 14'({r.user_word2_part_b, r.user_word2_part_a} >> 2)
                  : 14'({r.user_word1_part_b, r.user_word1_part_a} >> 2);
            f = 1'b0;
         end
         ADTP_M_BIT_TGL: begin
            w = `ADTP_PAT_CHK_A;
            f = 1'b0;
         end
         ADTP_M_SYNC: begin
            w = sh ? `ADTP_PAT_SYNC12 : `ADTP_PAT_SYNC14;
            f = 1'b0;
         end
         ADTP_M_ONE_BIT: begin
            w = `ADTP_PAT_ONEBIT;
            f = 1'b0;
         end
         ADTP_M_MIXED: begin
            w = sh ? `ADTP_PAT_MIX12 : `ADTP_PAT_MIX14;
            f = 1'b0;
         end
         default:         w = conv;
      endcase
      return f ? adtp_fmt(w, tw) : w;
   endfunction

   // Pattern engine and request side of the crossing, one slot per bank.
   // A new word set is built only once the link side has taken the last,
   // so the sequences and pairs never skip a word at the lanes.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         for (int b = 0; b < 2; b++) begin
            pn9[b]  <= `ADTP_PN_SEED;
            long_prbs[b] <= `ADTP_PN_SEED;
            hold[b] <= '0;
         end
         alt      <= 2'b00;
         req      <= 2'b00;
         ack_meta <= 2'b00;
         ack_sync <= 2'b00;
      end else begin
         ack_meta <= ack_out;
         ack_sync <= ack_meta;
         for (int b = 0; b < 2; b++) begin
            logic [36:0] s9;
            logic [36:0] s23;
            logic        prbs_mode;
            logic        pn_long;
            logic        pn_short;
            logic        sh;
            s9        = adtp_prbs_step(pn9[b], `ADTP_PN9_LEN, `ADTP_PN9_TAP);
            s23       = adtp_prbs_step(long_prbs[b], `ADTP_LONG_PRBS_LEN, `ADTP_LONG_PRBS_TAP);
            pn_long   = regs[b].test_pattern_select[`ADTP_MODE_MSB:0] == ADTP_M_PN_LONG;
            pn_short  = regs[b].test_pattern_select[`ADTP_MODE_MSB:0] == ADTP_M_PN_SHORT;
            prbs_mode = pn_long || pn_short;
            sh        = res_12bit_sel && !prbs_mode && !strap_pat;
            if (regs[b].test_pattern_select[`ADTP_PN_RST_LO] ||
                regs[b].test_pattern_select[`ADTP_PN_RST_HI]) begin
               pn9[b]  <= `ADTP_PN_SEED;
               long_prbs[b] <= `ADTP_PN_SEED;
            end else if (req[b] == ack_sync[b] && strap_done) begin
               for (int c = 0; c < 8; c++) begin
                  hold[b].word[c] <= strap_pat ? `ADTP_PAT_STRAP
                     : adtp_pick(regs[b], alt[b], sh, s9[36:23], s23[36:23],
                                 conv_data[b*8+c], twos);
               end
               hold[b].short_frame <= sh;
               // Each generator sits at its seed unless its own mode is in use,
               // so switching from one sequence to the other starts it afresh.
               pn9[b]  <= pn_short ? s9[22:0] : `ADTP_PN_SEED;
               // The stream here starts with ones, the complement of the reference.
               long_prbs[b] <= pn_long ? s23[22:0] : `ADTP_PN_SEED;
               alt[b]  <= ~alt[b];
               req[b]  <= ~req[b];
            end
         end
      end
   end

   // Link domain: its own reset release, request sync and the lane shifters.
   logic [1:0]            link_rst_q;   // Reset release chain for link_clk.
   logic                  link_rst;     // Link side reset, released on link_clk.
   logic [1:0]            req_meta;     // Request sync, first stage.
   logic [1:0]            req_sync;     // Request sync, second stage.
   logic [3:0]            bit_cnt [2];  // Bit position inside the frame.
   logic [1:0]            short_q;      // Current frame is 12 bits.
   logic [7:0][13:0]      shift [2];    // Lane shifters, MSB leaves first.
   logic [7:0][13:0]      last [2];     // Last word set, resent when none waits.
   logic [1:0]            fclk_q;       // Frame clock per bank.
   logic [1:0]            dclk_q;       // Data clock per bank.

   assign link_rst = link_rst_q[1];

   // Reset asserts at once and releases after two link edges.
   always_ff @(posedge link_clk or posedge rst) begin
      if (rst) begin
         link_rst_q <= 2'b11;
      end else begin
         link_rst_q <= {link_rst_q[0], 1'b0};
      end
   end

   // Frames run free so the receiver always sees both clocks.
   always_ff @(posedge link_clk or posedge link_rst) begin
      if (link_rst) begin
         req_meta <= 2'b00;
         req_sync <= 2'b00;
         ack_out  <= 2'b00;
         short_q  <= 2'b00;
         fclk_q   <= 2'b00;
         dclk_q   <= 2'b00;
         for (int b = 0; b < 2; b++) begin
            bit_cnt[b] <= `ADTP_LAST14;
            shift[b]   <= '0;
            last[b]    <= '0;
         end
      end else begin
         req_meta <= req;
         req_sync <= req_meta;
         for (int b = 0; b < 2; b++) begin
            dclk_q[b] <= ~dclk_q[b];
            if (bit_cnt[b] == (short_q[b] ? `ADTP_LAST12 : `ADTP_LAST14)) begin
               bit_cnt[b] <= 4'h0;
               fclk_q[b]  <= 1'b1;
               // The offered set is stable while request and acknowledge differ.
               if (req_sync[b] != ack_out[b]) begin
                  shift[b]   <= hold[b].word;
                  last[b]    <= hold[b].word;
                  short_q[b] <= hold[b].short_frame;
                  ack_out[b] <= req_sync[b];
               end else begin
                  shift[b] <= last[b];
               end
            end else begin
               bit_cnt[b] <= 4'(bit_cnt[b] + 4'h1);
               fclk_q[b]  <= (4'(bit_cnt[b] + 4'h1) <
                              (short_q[b] ? `ADTP_HALF12 : `ADTP_HALF14));
               for (int c = 0; c < 8; c++) begin
                  shift[b][c] <= {shift[b][c][12:0], 1'b0};
               end
            end
         end
      end
   end

   // Each lane shows its shifter's top bit.
   always_comb begin
      for (int b = 0; b < 2; b++) begin
         for (int c = 0; c < 8; c++) begin
            serial_data_lanes[b*8+c] = shift[b][c][13];
         end
      end
   end

   assign bank1_frame_clock = fclk_q[0];
   assign bank2_frame_clock = fclk_q[1];
   assign bank1_data_clock  = dclk_q[0];
   assign bank2_data_clock  = dclk_q[1];

endmodule // adtp_pattern_gen

// ### tb/adtp_checker.sv
`timescale 1ns/1ps
`include "adtp_cfg.svh"
// Pin-level checks: lane framing on link_clk, register port on sys_clk.
module adtp_checker
   import adtp_pkg::*;
(
   input wire logic                   sys_clk,
   input wire logic                   rst,
   input wire logic                   link_clk,
   input wire logic                   bank1_chip_select_n,
   input wire logic                   bank2_chip_select_n,
   input wire adtp_pkg::adtp_cfg_wr_t cfg_wr,
   input wire logic [7:0]             cfg_rd_addr,
   input wire logic [7:0]             cfg_rdata,
   input wire logic                   bank1_frame_clock,
   input wire logic                   bank2_frame_clock,
   input wire logic                   bank1_data_clock,
   input wire logic                   bank2_data_clock
);
   logic [1:0] cs_q;   // Select pins one edge ago.
   logic [1:0] cs_age; // Edges the selects held still, saturating at 3.
   // Selects pass a synchroniser, so a write is judged only once they settled.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cs_q   <= 2'h3;
         cs_age <= 2'h0;
      end else begin
         cs_q <= {bank2_chip_select_n, bank1_chip_select_n};
         if (cs_q != {bank2_chip_select_n, bank1_chip_select_n}) begin
            cs_age <= 2'h0;
         end else if (cs_age != 2'h3) begin
            cs_age <= cs_age + 2'h1;
         end
      end
   end
   function automatic logic mapped(input logic [7:0] a);
      return a == `ADTP_OFF_TEST_SEL || (a >= `ADTP_OFF_USER1_A && a <= `ADTP_OFF_USER2_B);
   endfunction
   // A settled write to the address being read, then one quiet cycle.
   sequence wr_seen(logic [1:0] lvl);
      cfg_wr.wr_en && cfg_wr.addr == cfg_rd_addr && mapped(cfg_rd_addr) && cs_age == 2'h3
      && cs_q == lvl ##1 !cfg_wr.wr_en && $stable(cfg_rd_addr);
   endsequence
   sequence frame_head(logic f);
      f [*6];
   endsequence
   property frame_shape(logic f);
      @(posedge link_clk) disable iff (rst) $rose(f) |-> frame_head(f) ##[1:2] !f;
   endproperty
   property frame_gap(logic f);
      @(posedge link_clk) disable iff (rst) $fell(f) |-> (!f) [*6] ##[1:2] f;
   endproperty
   property dclk_runs(logic c);
      @(posedge link_clk) disable iff (rst) c != $past(c) |=> c != $past(c);
   endproperty
   dclk1_run_a: assert property (dclk_runs(bank1_data_clock))
      else $error("bank 1 data clock stopped");
   dclk2_run_a: assert property (dclk_runs(bank2_data_clock))
      else $error("bank 2 data clock stopped");
   frame1_shape_a: assert property (frame_shape(bank1_frame_clock))
      else $error("bank 1 frame high time wrong");
   frame2_shape_a: assert property (frame_shape(bank2_frame_clock))
      else $error("bank 2 frame high time wrong");
   frame1_gap_a: assert property (frame_gap(bank1_frame_clock))
      else $error("bank 1 frame low time wrong");
   frame2_gap_a: assert property (frame_gap(bank2_frame_clock))
      else $error("bank 2 frame low time wrong");
   cfg_readback_a: assert property (@(posedge sys_clk) disable iff (rst)
      wr_seen(2'h0) |=> cfg_rdata == $past(cfg_wr.wdata, 2))
      else $error("readback differs from written byte");
   desel_ignore_a: assert property (@(posedge sys_clk) disable iff (rst)
      wr_seen(2'h3) |=> $stable(cfg_rdata))
      else $error("write taken while deselected");
   unmapped_read_a: assert property (@(posedge sys_clk) disable iff (rst)
      $stable(cfg_rd_addr) && !mapped(cfg_rd_addr) |-> cfg_rdata == 8'h00)
      else $error("unmapped read not zero");
endmodule // adtp_checker

bind adtp_pattern_gen adtp_checker u_chk (
   .sys_clk, .rst, .link_clk, .bank1_chip_select_n, .bank2_chip_select_n, .cfg_wr,
   .cfg_rd_addr, .cfg_rdata, .bank1_frame_clock, .bank2_frame_clock,
   .bank1_data_clock, .bank2_data_clock
);

// ### tb/adtp_rx_model.sv
`timescale 1ns/1ps
// Receiver for one lane. It hands back a word when the frame clock rises,
// since only then is the previous frame known to be complete.
module adtp_rx_model (
   input  wire logic        link_clk,
   input  wire logic        frame_clock,
   input  wire logic        lane,
   input  wire logic        short_frame,
   output logic [13:0]      word,
   output logic             word_valid
);
   logic [13:0] shift_q; // Received bits, newest in bit 0.
   logic        fc_q;    // Frame clock one bit time earlier.
   always_ff @(posedge link_clk) begin
      shift_q    <= {shift_q[12:0], lane};
      fc_q       <= frame_clock;
      word_valid <= frame_clock && !fc_q;
      if (frame_clock && !fc_q) begin
         word <= short_frame ? {shift_q[11:0], 2'h0} : shift_q;
      end
   end
endmodule // adtp_rx_model

// ### tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   import adtp_pkg::*;
   logic          sys_clk = 1'b0;
   logic          link_clk = 1'b0;
   logic          rst = 1'b1;
   logic          pat_strap = 1'b0;
   logic          fmt_strap = 1'b1; // Twos complement while both selects high.
   logic          cs1_n = 1'b1;
   logic          cs2_n = 1'b1;
   adtp_cfg_wr_t  cfg_wr = '0;
   logic [7:0]    rd_addr = 8'h00;
   logic [7:0]    rdata;
   logic          res12 = 1'b0;
   logic          rx12 = 1'b0;  // Frame length the receiver expects.
   logic          twos = 1'b0;
   adtp_samples_t conv = '0;
   logic [15:0]   lanes;
   logic [3:0]    clk_out;      // Frame then data clocks of both banks.
   logic [13:0]   w1;
   logic [13:0]   w2;
   logic          v1;
   logic          v2;
   logic [13:0]   exp_q[$];
   int            n_mismatch = 0;
   int            checks = 0;
   int            guard = 0;
   int            seed = 32'ha347af5d;
   logic [3:0]    codes[11] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h7, 4'h8, 4'h9, 4'ha, 4'hb, 4'hc};
   logic [7:0]    addrs[6] = '{8'h0d, 8'h19, 8'h1a, 8'h1b, 8'h1c, 8'h20};
   always #4 sys_clk = ~sys_clk;
   always #6 link_clk = ~link_clk;
   adtp_pattern_gen u_dut (
      .sys_clk, .rst, .link_clk, .serial_clock_pattern_strap_pin(pat_strap),
      .serial_io_format_strap_pin(fmt_strap), .bank1_chip_select_n(cs1_n),
      .bank2_chip_select_n(cs2_n), .cfg_wr, .cfg_rd_addr(rd_addr), .cfg_rdata(rdata),
      .res_12bit_sel(res12), .twos_comp_sel(twos), .conv_data(conv),
      .serial_data_lanes(lanes), .bank1_frame_clock(clk_out[0]),
      .bank2_frame_clock(clk_out[1]), .bank1_data_clock(clk_out[2]),
      .bank2_data_clock(clk_out[3]));
   adtp_rx_model u_rx1 (.link_clk, .frame_clock(clk_out[0]), .lane(lanes[0]),
      .short_frame(rx12), .word(w1), .word_valid(v1));
   adtp_rx_model u_rx2 (.link_clk, .frame_clock(clk_out[1]), .lane(lanes[8]),
      .short_frame(rx12), .word(w2), .word_valid(v2));
   task automatic chk(input logic [13:0] seen, input logic [13:0] want);
      checks++;
      if (seen !== want) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t seen=%h want=%h", $time, seen, want);
      end
   endtask
   task automatic complete_run();
      $display("checks=%0d mismatches=%0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // One bit time; a wait that runs too long ends the run as a failure.
   task automatic tick();
      @(negedge link_clk);
      guard++;
      if (guard > 4000) begin
         n_mismatch++;
         complete_run();
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      cfg_wr <= '{1'b1, a, d};
      @(posedge sys_clk);
      cfg_wr <= '0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] want);
      @(posedge sys_clk);
      rd_addr <= a;
      repeat (2) @(posedge sys_clk);
      #1 chk({6'h00, rdata}, {6'h00, want});
      @(posedge sys_clk);
   endtask
   // Waits for word e0 on bank 1 lane A, then queues the two words due next.
   task automatic stream(input logic [13:0] e0, input logic [13:0] e1, input logic [13:0] e2);
      guard = 0;
      while (!(v1 === 1'b1 && w1 === e0)) tick();
      @(posedge link_clk);
      exp_q.push_back(e1);
      exp_q.push_back(e2);
      while (exp_q.size() != 0) tick();
      @(posedge sys_clk);
      $display("test with lead word %h done", e0);
   endtask
   // Watcher: each word the receiver completes retires the oldest note.
   always @(negedge link_clk) begin
      if (v1 === 1'b1 && exp_q.size() > 0) begin
         chk(w1, exp_q.pop_front());
      end
   end
   initial begin
      logic [13:0] a;
      logic [13:0] b;
      logic [31:0] r;
      logic [31:0] u;
      for (int i = 0; i < 16; i++) begin
         conv[i] <= 14'($random(seed));
      end
      repeat (10) @(posedge sys_clk);
      rst <= 1'b0;
      stream(conv[0] ^ 14'h2000, conv[0] ^ 14'h2000, conv[0] ^ 14'h2000);
      cs1_n <= 1'b0;
      cs2_n <= 1'b0;
      repeat (4) @(posedge sys_clk);
      for (int i = 0; i < 6; i++) begin
         rd(addrs[i], 8'h00);
      end
      u = $random(seed);
      for (int i = 0; i < 4; i++) begin
         wr(8'h19 + 8'(i), u[8*i +: 8]);
      end
      rd(8'h1b, u[23:16]);
      rd(8'h0d, 8'h00);
      for (int i = 0; i < 11; i++) begin
         r = $random(seed);
         res12 <= r[0];
         rx12 <= r[0];
         twos <= r[1];
         case (codes[i])
            4'h0: {a, b} = {2{conv[0]}};
            4'h1: {a, b} = {2{14'h2000}};
            4'h2: {a, b} = {2{14'h3fff}};
            4'h3: {a, b} = {2{14'h0000}};
            4'h4: {a, b} = {14'h2aaa, 14'h1555};
            4'h7: {a, b} = {14'h3fff, 14'h0000};
            4'h8: {a, b} = u_words(u);
            4'h9: {a, b} = {2{14'h2aaa}};
            4'ha: {a, b} = {2{r[0] ? 14'h00fc : 14'h007f}};
            4'hb: {a, b} = {2{14'h2000}};
            default: {a, b} = {2{r[0] ? 14'h28cc : 14'h2867}};
         endcase
         if (codes[i] <= 4'h3 && r[1]) begin
            a = a ^ 14'h2000;
            b = b ^ 14'h2000;
         end
         if (r[0]) begin
            a = a & 14'h3ffc;
            b = b & 14'h3ffc;
         end
         wr(8'h0d, {4'h0, codes[i]});
         stream(a, b, a);
      end
      res12 <= 1'b1;
      rx12 <= 1'b0;
      twos <= 1'b0;
      wr(8'h0d, 8'h06);
      stream(14'h3fe0, 14'h3df1, 14'h1cc8);
      twos <= 1'b1;
      wr(8'h0d, 8'h05);
      stream(14'h1fff, 14'h1fe0, 14'h2001);
      wr(8'h0d, 8'h15);
      repeat (60) @(posedge sys_clk);
      wr(8'h0d, 8'h05);
      stream(14'h1fe0, 14'h2001, 14'h1c00);
      twos <= 1'b0;
      res12 <= 1'b0;
      wr(8'h0d, 8'h00);
      cs2_n <= 1'b1;
      repeat (4) @(posedge sys_clk);
      wr(8'h0d, 8'h02);
      stream(14'h3fff, 14'h3fff, 14'h3fff);
      guard = 0;
      while (v2 !== 1'b1) tick();
      chk(w2, conv[8]);
      @(posedge sys_clk);
      cs1_n <= 1'b1;
      cs2_n <= 1'b0;
      repeat (4) @(posedge sys_clk);
      rd(8'h0d, 8'h00);
      cs2_n <= 1'b1;
      repeat (4) @(posedge sys_clk);
      wr(8'h0d, 8'h03);
      cs1_n <= 1'b0;
      cs2_n <= 1'b0;
      repeat (4) @(posedge sys_clk);
      rd(8'h0d, 8'h02);
      rst <= 1'b1;
      pat_strap <= 1'b1;
      cs1_n <= 1'b1;
      cs2_n <= 1'b1;
      repeat (10) @(posedge sys_clk);
      rst <= 1'b0;
      stream(14'h2000, 14'h2000, 14'h2000);
      complete_run();
   end
   // User words: the byte pair forms 16 bits whose top 14 are sent.
   function automatic logic [27:0] u_words(input logic [31:0] v);
      return {v[15:2], v[31:18]};
   endfunction
endmodule // tb_top
